// >>> logic/timer_pkg.sv
// Purpose: Shared constants for the timer module core.
// Assumes: Byte-wide register port, one system clock.
// Notes: Register indices are byte addresses on the register port.
package timer_pkg;
  // ***********************************************
  // Register indices.
  // ***********************************************
  localparam logic [3:0] ADDR_CTRL0 = 4'h0; // Pause, clock select, run, period.
  localparam logic [3:0] ADDR_CTRL1 = 4'h1; // Mode, action, level, polarity, single pulse, clear select.
  localparam logic [3:0] ADDR_CNT_L = 4'h2; // Count low byte, via holding buffer.
  localparam logic [3:0] ADDR_CNT_H = 4'h3; // Count high byte.
  localparam logic [3:0] ADDR_CMPA_L = 4'h4; // Compare A low byte.
  localparam logic [3:0] ADDR_CMPA_H = 4'h5; // Compare A high byte.
  localparam logic [3:0] ADDR_CMPB_L = 4'h6; // Compare B low byte.
  localparam logic [3:0] ADDR_CMPB_H = 4'h7; // Compare B high byte.
  localparam logic [3:0] ADDR_CAP_CFG = 4'h8; // Capture enable and edge select.
  localparam logic [3:0] ADDR_CAP_L = 4'h9; // Captured count low byte.
  localparam logic [3:0] ADDR_CAP_H = 4'hA; // Captured count high byte.
  localparam logic [3:0] ADDR_INT_STAT = 4'hB; // Sticky event flags, write one to clear.
  localparam logic [3:0] ADDR_INT_MASK = 4'hC; // Interrupt mask, same layout.
  // ***********************************************
  // Field positions and codes.
  // ***********************************************
  localparam int C0_PAUSE = 7;
  localparam int C0_RUN = 3;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_SP = 1;
  localparam int C1_CCLR = 0;
  localparam int CAP_EN = 2;
  localparam int ST_A = 0;
  localparam int ST_P = 1;
  localparam int ST_B = 2;
  localparam int ST_CAP = 3;
  localparam int ST_W = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int PRESC_SYS = 4; // System clock divided by four.
  localparam int PRESC_H1 = 16; // High clock divided by sixteen.
  localparam int PRESC_H2 = 64; // High clock divided by sixty-four.
  typedef enum logic [2:0] {
    CK_SYS4 = 3'b000, CK_SYS = 3'b001, CK_H16 = 3'b010, CK_H64 = 3'b011,
    CK_TBC = 3'b100, CK_RSVD = 3'b101, CK_EXT_R = 3'b110, CK_EXT_F = 3'b111
  } clk_sel_t;
  typedef enum logic [1:0] {
    MD_CMP = 2'b00, MD_UNDEF = 2'b01, MD_PWM = 2'b10, MD_TIMER = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_LOW = 2'b01, ACT_HIGH = 2'b10, ACT_TOGGLE = 2'b11
  } pin_act_t;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00, EDGE_FALL = 2'b01, EDGE_BOTH = 2'b10, EDGE_NONE = 2'b11
  } cap_edge_t;
endpackage : timer_pkg

// >>> logic/count_tick_if.sv
// Purpose: Carries clock selection and count ticks between timer modules.
// Assumes: Single clock domain.
// Notes: Edge pulses are one cycle wide.
`timescale 1ns/1ps
interface count_tick_if;
  timer_pkg::clk_sel_t sel; // Selected count clock source.
  logic ext_rise; // Rising edge seen on the external count pin.
  logic ext_fall; // Falling edge seen on the external count pin.
  logic tick; // One-cycle count advance.
  modport core (output sel, output ext_rise, output ext_fall, input tick);
  modport gen (input sel, input ext_rise, input ext_fall, output tick);
endinterface : count_tick_if

// >>> logic/edge_sync.sv
// Purpose: Synchronises a pin and reports its edges as single pulses.
// Assumes: Pin is asynchronous to the clock.
// Notes: Adds two cycles of latency from pin to pulse.
`timescale 1ns/1ps
module edge_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic meta_reg; // First stage, read only by the second.
  logic sync_reg; // Second stage.
  logic prev_reg; // Delayed copy for edge detection.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges compare stable stages only, so each transition yields one pulse.
  assign rise = ce & sync_reg & ~prev_reg;
  assign fall = ce & ~sync_reg & prev_reg;
endmodule : edge_sync

// >>> logic/count_clock_gen.sv
// Purpose: Produces count ticks from the selected clock source.
// Assumes: High and time base clocks arrive as one-cycle enables.
// Notes: The reserved code gives no ticks at all.
`timescale 1ns/1ps
module count_clock_gen (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic fh_tick,
  input wire logic tbc_tick,
  count_tick_if.gen tif
);
  logic [5:0] hdiv_reg; // Divider on high clock enables.
  logic [1:0] sdiv_reg; // Divider on the system clock.

  // Free-running prescalers; they keep running so rates stay steady across reselection.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdiv_reg <= 6'h00;
      sdiv_reg <= 2'h0;
    end else if (ce) begin
      sdiv_reg <= sdiv_reg + 2'h1;
      if (fh_tick) begin
        hdiv_reg <= hdiv_reg + 6'h01;
      end
    end
  end

  always_comb begin
    unique case (tif.sel)
      timer_pkg::CK_SYS4: tif.tick = ce && (sdiv_reg == 2'(timer_pkg::PRESC_SYS - 1));
      timer_pkg::CK_SYS: tif.tick = ce;
      timer_pkg::CK_H16: tif.tick = ce && fh_tick && (hdiv_reg[3:0] == 4'(timer_pkg::PRESC_H1 - 1));
      timer_pkg::CK_H64: tif.tick = ce && fh_tick && (hdiv_reg == 6'(timer_pkg::PRESC_H2 - 1));
      timer_pkg::CK_TBC: tif.tick = ce && tbc_tick;
      timer_pkg::CK_RSVD: tif.tick = 1'b0;
      timer_pkg::CK_EXT_R: tif.tick = tif.ext_rise;
      timer_pkg::CK_EXT_F: tif.tick = tif.ext_fall;
    endcase
  end
endmodule : count_clock_gen

// >>> logic/timer_core.sv
// Purpose: Counter, comparators, capture, output pin and byte registers of one timer unit.
// Assumes: Byte register port, synchronous strobes, clock at 125 MHz.
// Notes: Compact units tie HAS_B low; enhanced units set it.
// Overview of operation
// - count up, compare, interrupt, clear, drive pin
// - reserved clock code stops counting
// - clock from prescaled, high, time base, pin
// - compare A and P each interrupt
// - enhanced unit adds comparator B interrupt
// - pin count clock on either edge
// - count pin triggers single pulse
// - capture on rising, falling or both
// - compare match sets, clears, toggles pin
// - output pin carries PWM waveform
// - high byte direct, low via buffer
// - low write buffers, high write commits
// - high read latches low into buffer
// - ten-bit counter, period matches top bits
// - run rising edge clears the count
`timescale 1ns/1ps
module timer_core #(
  parameter int CNT_W = 10,
  parameter bit HAS_B = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic fh_tick,
  input wire logic tbc_tick,
  input wire logic ext_count_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_output_pin,
  output logic irq
);
  // ***********************************************
  // Elaboration checks and declarations.
  // ***********************************************
  if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 9 and 16");
  end
  localparam int HI_W = CNT_W - 8;
  localparam int LO_P = CNT_W - 3; // Bits below the period field.
  localparam int ST_W_L = timer_pkg::ST_W; // Count of status flags, needed before the flag registers.

  count_tick_if tif ();
  logic [7:0] ctrl0_reg; // Pause, clock select, run, period.
  logic [7:0] ctrl1_reg; // Mode and pin controls.
  logic [2:0] capcfg_reg; // Capture enable and edge.
  logic [CNT_W-1:0] cnt_reg; // Main count.
  logic [CNT_W-1:0] cmp_a_reg; // Compare value A.
  logic [CNT_W-1:0] cmp_b_reg; // Compare value B.
  logic [CNT_W-1:0] cap_reg; // Captured count.
  logic [7:0] buf_reg; // Shared low-byte holding buffer.
  logic [7:0] rdata_reg; // Read data, valid the cycle after the strobe.
  logic [ST_W_L-1:0] stat_reg; // Sticky event flags.
  logic [ST_W_L-1:0] mask_reg; // Interrupt mask.
  logic run_prev_reg; // Run bit last cycle, for its rising edge.
  logic out_reg; // Output pin level.
  logic run_rise, tick, cap_rise, cap_fall, cap_hit, trig;
  logic match_a, match_b, match_p, clr_a;
  logic [CNT_W-1:0] cnt_next;
  logic [ST_W_L-1:0] events;
  timer_pkg::mode_t mode;
  timer_pkg::pin_act_t act;

  assign tif.sel = timer_pkg::clk_sel_t'(ctrl0_reg[6:4]);
  assign mode = timer_pkg::mode_t'(ctrl1_reg[7:6]);
  assign act = timer_pkg::pin_act_t'(ctrl1_reg[5:4]);

  // ***********************************************
  // Pin synchronisers and clock source.
  // ***********************************************
  edge_sync u_ext_sync (
    .clock(clock), .rst_n(rst_n), .ce(ce), .pin(ext_count_clock_pin),
    .rise(tif.ext_rise), .fall(tif.ext_fall)
  );
  edge_sync u_cap_sync (
    .clock(clock), .rst_n(rst_n), .ce(ce), .pin(capture_input_pin),
    .rise(cap_rise), .fall(cap_fall)
  );
  count_clock_gen u_clk (
    .clock(clock), .rst_n(rst_n), .ce(ce), .fh_tick(fh_tick), .tbc_tick(tbc_tick), .tif(tif)
  );

  // ***********************************************
  // Counter and comparators.
  // ***********************************************
  // The counter only advances while running and not paused.
  assign tick = tif.tick && ctrl0_reg[timer_pkg::C0_RUN] && !ctrl0_reg[timer_pkg::C0_PAUSE];
  assign run_rise = ce && ctrl0_reg[timer_pkg::C0_RUN] && !run_prev_reg;
  assign cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  // period on top bits
  // A zero period field matches the natural wrap, i.e. overflow at full count.
  assign match_p = tick && (cnt_next[CNT_W-1:LO_P] == ctrl0_reg[2:0]) && (cnt_next[LO_P-1:0] == '0);
  assign match_a = tick && (cnt_next == cmp_a_reg);
  assign match_b = HAS_B && tick && (cnt_next == cmp_b_reg);
  assign clr_a = match_a && ctrl1_reg[timer_pkg::C1_CCLR];
  // single pulse trigger
  // The count pin acts as trigger only while single pulse is enabled in compare mode.
  assign trig = ctrl1_reg[timer_pkg::C1_SP] && (mode == timer_pkg::MD_CMP) && tif.ext_rise;

  // Counter update; the run edge and the trigger restart from zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      run_prev_reg <= 1'b0;
    end else if (ce) begin
      run_prev_reg <= ctrl0_reg[timer_pkg::C0_RUN];
      if (run_rise || trig) begin
        cnt_reg <= '0;
      end else if (clr_a || (match_p && !ctrl1_reg[timer_pkg::C1_CCLR])) begin
        cnt_reg <= '0;
      end else if (tick) begin
        cnt_reg <= cnt_next;
      end
    end
  end

  // ***********************************************
  // Output pin.
  // ***********************************************
  // Pin level follows the mode; pin sharing is owned by the port logic outside.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (ce) begin
      if (mode == timer_pkg::MD_PWM) begin
        out_reg <= (cnt_reg < cmp_a_reg) ^ ctrl1_reg[timer_pkg::C1_POL];
      end else if (mode == timer_pkg::MD_CMP) begin
        if (run_rise) begin
          out_reg <= ctrl1_reg[timer_pkg::C1_OC];
        end else if (trig) begin
          out_reg <= ~ctrl1_reg[timer_pkg::C1_OC];
        end else if (match_a) begin
          unique case (act)
            timer_pkg::ACT_NONE: out_reg <= out_reg;
            timer_pkg::ACT_LOW: out_reg <= 1'b0;
            timer_pkg::ACT_HIGH: out_reg <= 1'b1;
            timer_pkg::ACT_TOGGLE: out_reg <= ~out_reg;
          endcase
        end
      end
    end
  end
  assign timer_output_pin = out_reg;

  // ***********************************************
  // Capture.
  // ***********************************************
  // capture edge select
  always_comb begin
    unique case (timer_pkg::cap_edge_t'(capcfg_reg[1:0]))
      timer_pkg::EDGE_RISE: cap_hit = cap_rise;
      timer_pkg::EDGE_FALL: cap_hit = cap_fall;
      timer_pkg::EDGE_BOTH: cap_hit = cap_rise | cap_fall;
      timer_pkg::EDGE_NONE: cap_hit = 1'b0;
    endcase
  end

  // The captured count stays until the next qualifying edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg <= '0;
    end else if (ce && cap_hit && capcfg_reg[timer_pkg::CAP_EN]) begin
      cap_reg <= cnt_reg;
    end
  end

  // ***********************************************
  // Interrupt flags.
  // ***********************************************
  // A, P, B and capture sources
  assign events = {cap_hit && capcfg_reg[timer_pkg::CAP_EN], match_b, match_p, match_a};

  // A set in the same cycle as a clearing write wins, so no event is lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else if (ce) begin
      if (wr && addr == timer_pkg::ADDR_INT_MASK) begin
        mask_reg <= wdata[ST_W_L-1:0];
      end
      if (wr && addr == timer_pkg::ADDR_INT_STAT) begin
        stat_reg <= (stat_reg & ~wdata[ST_W_L-1:0]) | events;
      end else begin
        stat_reg <= stat_reg | events;
      end
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // ***********************************************
  // Register port and byte buffer.
  // ***********************************************
  // Control registers and compare values; the counter is read only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg <= timer_pkg::RESET_BYTE;
      ctrl1_reg <= timer_pkg::RESET_BYTE;
      capcfg_reg <= '0;
      cmp_a_reg <= '0;
      cmp_b_reg <= '0;
    end else if (ce && wr) begin
      unique case (addr)
        timer_pkg::ADDR_CTRL0: ctrl0_reg <= wdata;
        timer_pkg::ADDR_CTRL1: ctrl1_reg <= wdata;
        timer_pkg::ADDR_CAP_CFG: capcfg_reg <= wdata[2:0];
        timer_pkg::ADDR_CMPA_H: cmp_a_reg <= {wdata[HI_W-1:0], buf_reg};
        timer_pkg::ADDR_CMPB_H: if (HAS_B) begin
          cmp_b_reg <= {wdata[HI_W-1:0], buf_reg};
        end
        default: ;
      endcase
    end
  end

  // shared low-byte buffer
  // Only low writes and high reads move the buffer, so the sequence order matters.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= timer_pkg::RESET_BYTE;
    end else if (ce) begin
      if (wr && (addr == timer_pkg::ADDR_CMPA_L || addr == timer_pkg::ADDR_CMPB_L)) begin
        buf_reg <= wdata;
      end else if (rd) begin
        unique case (addr)
          timer_pkg::ADDR_CNT_H: buf_reg <= cnt_reg[7:0];
          timer_pkg::ADDR_CMPA_H: buf_reg <= cmp_a_reg[7:0];
          timer_pkg::ADDR_CMPB_H: buf_reg <= cmp_b_reg[7:0];
          timer_pkg::ADDR_CAP_H: buf_reg <= cap_reg[7:0];
          default: ;
        endcase
      end
    end
  end

  // Read data registered; unmapped addresses and reserved bits read zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= timer_pkg::RESET_BYTE;
    end else if (ce) begin
      rdata_reg <= timer_pkg::RESET_BYTE;
      if (rd) begin
        unique case (addr)
          timer_pkg::ADDR_CTRL0: rdata_reg <= ctrl0_reg;
          timer_pkg::ADDR_CTRL1: rdata_reg <= ctrl1_reg;
          timer_pkg::ADDR_CNT_L, timer_pkg::ADDR_CMPA_L, timer_pkg::ADDR_CMPB_L,
          timer_pkg::ADDR_CAP_L: rdata_reg <= buf_reg;
          timer_pkg::ADDR_CNT_H: rdata_reg <= 8'(cnt_reg[CNT_W-1:8]);
          timer_pkg::ADDR_CMPA_H: rdata_reg <= 8'(cmp_a_reg[CNT_W-1:8]);
          timer_pkg::ADDR_CMPB_H: rdata_reg <= 8'(cmp_b_reg[CNT_W-1:8]);
          timer_pkg::ADDR_CAP_H: rdata_reg <= 8'(cap_reg[CNT_W-1:8]);
          timer_pkg::ADDR_CAP_CFG: rdata_reg <= {5'h00, capcfg_reg};
          timer_pkg::ADDR_INT_STAT: rdata_reg <= 8'(stat_reg);
          timer_pkg::ADDR_INT_MASK: rdata_reg <= 8'(mask_reg);
          default: rdata_reg <= timer_pkg::RESET_BYTE;
        endcase
      end
    end
  end
  assign rdata = rdata_reg;

  // ***********************************************
  // Assertions.
  // ***********************************************
  a_reserved_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (tif.sel == timer_pkg::CK_RSVD) |-> !tick) else $error("count advanced on reserved clock");
  a_run_clear: assert property (@(posedge clock) disable iff (!rst_n)
    run_rise |=> (cnt_reg == '0)) else $error("count not cleared by run edge");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    (tick && !match_a && !match_p && !trig && !run_rise) |=> (cnt_reg == $past(cnt_next)))
    else $error("count did not advance by one");
  a_flag_a_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && match_a) |=> stat_reg[timer_pkg::ST_A]) else $error("compare A flag missing");
  a_flag_b_set: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && match_b) |=> stat_reg[timer_pkg::ST_B]) else $error("compare B flag missing");
  a_period_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && match_p && !ctrl1_reg[timer_pkg::C1_CCLR] && !run_rise && !trig) |=> (cnt_reg == '0))
    else $error("period match did not clear count");
  a_pin_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && match_a && mode == timer_pkg::MD_CMP && act == timer_pkg::ACT_TOGGLE && !run_rise && !trig)
    |=> (out_reg != $past(out_reg))) else $error("pin did not toggle on match");
  a_pwm_level: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && mode == timer_pkg::MD_PWM) |=> (out_reg == (($past(cnt_reg) < $past(cmp_a_reg)) ^
    $past(ctrl1_reg[timer_pkg::C1_POL])))) else $error("PWM level wrong");
  a_high_commit: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && wr && addr == timer_pkg::ADDR_CMPA_H) |=> (cmp_a_reg[7:0] == $past(buf_reg)))
    else $error("high write did not commit buffer");
  a_high_latch: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && rd && addr == timer_pkg::ADDR_CNT_H) ##1 (ce && rd && addr == timer_pkg::ADDR_CNT_L)
    |=> (rdata == $past(cnt_reg[7:0], 2))) else $error("low read not from latched buffer");
  a_capture_take: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cap_hit && capcfg_reg[timer_pkg::CAP_EN]) |=> (cap_reg == $past(cnt_reg)))
    else $error("capture missed");
endmodule : timer_core

// >>> test/test_timer_core.sv
// Purpose: Self-checking bench for the timer core through its byte register port and pins.
// Assumes: One 125 MHz clock, count ticks from the system clock, the time base enable or the count pin.
// Notes: Checks by pin and register reads only; the guarding assertions live in the design files.
`timescale 1ns/1ps
module test_timer_core;
  // ***********************************************
  // Stimulus and observation signals.
  // ***********************************************
  logic clock; // System clock, 8 ns period.
  logic rst_n; // Asynchronous reset, active low.
  logic ce; // Clock enable, held high throughout.
  logic [3:0] addr; // Register index.
  logic [7:0] wdata; // Write data.
  logic wr; // Write strobe.
  logic rd; // Read strobe.
  logic [7:0] rdata; // Read data, one cycle after the read strobe.
  logic [7:0] rv; // Last value read.
  logic [7:0] rl; // Low byte of the last paired read.
  logic fh_tick; // High clock enable, unused here.
  logic tbc_tick; // Time base enable.
  logic ext_count_clock_pin; // External count and trigger pin.
  logic capture_input_pin; // Capture pin.
  logic timer_output_pin; // Timer output pin.
  logic irq; // Interrupt level.
  int miscompares = 0; // Mismatches seen.
  int samples_checked = 0; // Comparisons made.

  timer_core #(.CNT_W(10), .HAS_B(1'h1)) i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fh_tick(fh_tick), .tbc_tick(tbc_tick),
    .ext_count_clock_pin(ext_count_clock_pin), .capture_input_pin(capture_input_pin),
    .timer_output_pin(timer_output_pin), .irq(irq));

  // The clock toggles every half period.
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // ***********************************************
  // Shared tasks.
  // ***********************************************
  // Compares a seen byte with the expected one and counts the result.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // One write cycle; the strobe drops at the edge that took it.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg
  // One read cycle; data is taken in the following cycle, after that edge settles.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    rd_reg(a, rv);
    chk(rv, exp);
  endtask : rd_chk
  // high byte first
  // Back-to-back reads with the strobe held: the high byte lands in rv, the buffered low byte in rl.
  task automatic rd_pair(input logic [3:0] ah, input logic [3:0] al);
    @(posedge clock);
    addr <= ah;
    rd <= 1'h1;
    @(posedge clock);
    addr <= al;
    #1;
    rv = rdata;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    rl = rdata;
  endtask : rd_pair
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  // Samples a pin-level output away from the edge to avoid a race with its update.
  // pin sharing outside
  // Pin sharing is set up outside the block, so the bench watches the output directly.
  task automatic pin_chk(input logic exp);
    #1;
    chk({7'h00, timer_output_pin}, {7'h00, exp});
  endtask : pin_chk
  task automatic irq_chk(input logic exp);
    #1;
    chk({7'h00, irq}, {7'h00, exp});
  endtask : irq_chk
  // Full pulses on the count pin, long enough to pass the synchroniser.
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge clock);
      ext_count_clock_pin <= 1'h1;
      wait_cyc(4);
      ext_count_clock_pin <= 1'h0;
      wait_cyc(4);
    end
  endtask : pulse_ext
  // Moves the capture pin, checks the capture flag, then clears every flag.
  task automatic cap_step(input logic v, input logic exp);
    @(posedge clock);
    capture_input_pin <= v;
    wait_cyc(8);
    rd_reg(timer_pkg::ADDR_INT_STAT, rv);
    chk({7'h00, rv[timer_pkg::ST_CAP]}, {7'h00, exp});
    wr_reg(timer_pkg::ADDR_INT_STAT, 8'hFF);
  endtask : cap_step
  task automatic restart(input logic [7:0] c0);
    wr_reg(timer_pkg::ADDR_CTRL0, 8'h00);
    wr_reg(timer_pkg::ADDR_CTRL0, c0);
  endtask : restart
  // Single place where the run ends.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ***********************************************
  // Watchdog: the tests need under 3000 cycles.
  // ***********************************************
  initial begin
    wait_cyc(20000);
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end

  // ***********************************************
  // Test sequence.
  // ***********************************************
  initial begin
    int i;
    rst_n = 1'h0;
    ce = 1'h1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    fh_tick = 1'h0;
    tbc_tick = 1'h0;
    ext_count_clock_pin = 1'h0;
    capture_input_pin = 1'h0;
    wait_cyc(12);
    rst_n <= 1'h1;
    wr_reg(timer_pkg::ADDR_CNT_H, 8'h03);
    rd_chk(timer_pkg::ADDR_CNT_H, 8'h00);
    rd_chk(timer_pkg::ADDR_INT_STAT, 8'h00);
    wr_reg(timer_pkg::ADDR_CMPA_L, 8'h5A);
    wr_reg(timer_pkg::ADDR_CMPA_H, 8'h02);
    wr_reg(timer_pkg::ADDR_CMPA_L, 8'h33);
    rd_chk(timer_pkg::ADDR_CMPA_H, 8'h02);
    rd_chk(timer_pkg::ADDR_CMPA_L, 8'h5A);
    $display("Test byte access finished");
    // Match A at 20 clears the count and toggles the pin; B at 10 only flags.
    wr_reg(timer_pkg::ADDR_CMPA_L, 8'h14);
    wr_reg(timer_pkg::ADDR_CMPA_H, 8'h00);
    wr_reg(timer_pkg::ADDR_CMPB_L, 8'h0A);
    wr_reg(timer_pkg::ADDR_CMPB_H, 8'h00);
    wr_reg(timer_pkg::ADDR_CTRL1, 8'h31);
    wr_reg(timer_pkg::ADDR_INT_MASK, 8'h01);
    restart(8'h18);
    for (i = 0; i < 60 && irq !== 1'h1; i++) begin
      @(posedge clock);
      #1;
    end
    irq_chk(1'h1);
    pin_chk(1'h1);
    wr_reg(timer_pkg::ADDR_CTRL0, 8'h10);
    rd_chk(timer_pkg::ADDR_INT_STAT, 8'h05);
    wr_reg(timer_pkg::ADDR_INT_MASK, 8'h00);
    irq_chk(1'h0);
    wr_reg(timer_pkg::ADDR_INT_MASK, 8'h01);
    wr_reg(timer_pkg::ADDR_INT_STAT, 8'h01);
    rd_chk(timer_pkg::ADDR_INT_STAT, 8'h04);
    irq_chk(1'h0);
    $display("Test compare match finished");
    restart(8'h58);
    pulse_ext(3);
    wait_cyc(40);
    rd_chk(timer_pkg::ADDR_CNT_H, 8'h00);
    rd_chk(timer_pkg::ADDR_CNT_L, 8'h00);
    // one count per chosen pin edge
    for (i = 0; i < 2; i++) begin
      restart(i == 0 ? 8'h68 : 8'h78);
      pulse_ext(5);
      wait_cyc(6);
      rd_pair(timer_pkg::ADDR_CNT_H, timer_pkg::ADDR_CNT_L);
      chk(rv, 8'h00);
      chk(rl, 8'h05);
    end
    // time base source
    // Two idle cycles let the run edge clear the count first, then seven enables give seven counts.
    restart(8'h48);
    wait_cyc(2);
    tbc_tick <= 1'h1;
    wait_cyc(7);
    tbc_tick <= 1'h0;
    rd_pair(timer_pkg::ADDR_CNT_H, timer_pkg::ADDR_CNT_L);
    chk(rl, 8'h07);
    $display("Test clock sources finished");
    // period code 1 clears at 128
    wr_reg(timer_pkg::ADDR_CTRL1, 8'h00);
    wr_reg(timer_pkg::ADDR_INT_STAT, 8'hFF);
    restart(8'h19);
    wait_cyc(150);
    wr_reg(timer_pkg::ADDR_CTRL0, 8'h11);
    rd_reg(timer_pkg::ADDR_INT_STAT, rv);
    chk({7'h00, rv[timer_pkg::ST_P]}, 8'h01);
    rd_pair(timer_pkg::ADDR_CNT_H, timer_pkg::ADDR_CNT_L);
    chk(rv, 8'h00);
    chk({7'h00, rl[7]}, 8'h00);
    $display("Test period finished");
    for (i = 0; i < 3; i++) begin
      wr_reg(timer_pkg::ADDR_CAP_CFG, 8'h04 | 8'(i));
      wr_reg(timer_pkg::ADDR_INT_STAT, 8'hFF);
      cap_step(1'h1, i != 1);
      cap_step(1'h0, i != 0);
    end
    $display("Test capture finished");
    // PWM high while count below A
    wr_reg(timer_pkg::ADDR_CMPA_L, 8'h64);
    wr_reg(timer_pkg::ADDR_CMPA_H, 8'h00);
    wr_reg(timer_pkg::ADDR_CTRL1, 8'h80);
    restart(8'h18);
    wait_cyc(20);
    pin_chk(1'h1);
    wait_cyc(150);
    pin_chk(1'h0);
    wr_reg(timer_pkg::ADDR_CTRL1, 8'h84);
    // The pin register picks up the new polarity one edge after the write lands.
    wait_cyc(1);
    pin_chk(1'h1);
    $display("Test pwm finished");
    wr_reg(timer_pkg::ADDR_CTRL1, 8'h13);
    restart(8'h18);
    wait_cyc(4);
    pin_chk(1'h0);
    pulse_ext(1);
    wait_cyc(6);
    pin_chk(1'h1);
    wait_cyc(120);
    pin_chk(1'h0);
    $display("Test single pulse finished");
    complete_run();
  end
endmodule : test_timer_core
